// ===== hdl/rex_core.sv
`timescale 1ns/10ps
// Functional notes
// - every instruction is one 12-bit word, most executing one per clock
// - data registers and all results are eight bits wide
// - a 5-bit operand field is banked by the bank select register only when its top bit is set
// - the accumulator lives outside the data address space
// - literal instructions take their byte from the opcode; one loads the accumulator
// - and, or, xor, complement go to accumulator or register in one clock
// - a fuse bit chooses whether carry feeds add and subtract
// - fuse bit 0 adds carry in, fuse bit 1 leaves it out
// - increment/decrement-and-test skip the next word on a zero result
// - arithmetic, shift, bit and move instructions take one clock unless skipping or writing data address 02
// - test-and-skip costs one cycle, or two when the skip is taken
// - bit set and bit clear change exactly one bit of a register
// - skip-if-set tests for one, skip-if-clear tests for zero
// - bit operations reach every mapped register, program counter and flags included
// - a taken skip also skips following page or bank prefixes, one cycle each
// - move-to-accumulator forms compute from a source that keeps its value
// - port control and option registers only by dedicated moves; mode also takes its low four bits from a program read
// - 12-bit program addresses; jump gives nine low bits, call eight
// - call saves the program counter, return restores it
// - writing or adding to data address 02 jumps indirectly or relatively
// - jumps, calls and returns flush the pipeline and refill from the target
// - system control sets bank, page bits, reads program memory or sleeps
// - system control takes one clock, program read four at full rate
// - instruction rate is the clock, or a quarter of it by fuse
module rex_core #(
   parameter int PC_W    = 12,
   parameter int STACK_D = 8
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   output logic [PC_W-1:0]       pmAddr,
   input  wire logic [11:0]      pmData,
   input  wire logic             carryInputFuseBit,
   input  wire logic             turboFuseBit,
   input  wire logic             wakePin,
   output logic [7:0]            modeReg,
   output logic [7:0]            optionReg,
   output logic [2:0]            portCtrlSel,
   output logic [7:0]            portCtrlData,
   output logic                  portCtrlWr,
   output logic                  wdtClear,
   output logic                  sleeping
);
   localparam int SP_W = $clog2(STACK_D);

   if (PC_W < 11 || PC_W > 12) begin : gBadPc
      $error("PC_W must be 11 or 12");
   end
   if (STACK_D < 2 || (1 << SP_W) != STACK_D) begin : gBadStack
      $error("STACK_D must be a power of two, at least 2");
   end

   // ==========================================================
   // pin synchronisers and rate divider
   logic [2:0] syncA_r;
   logic [2:0] syncB_r;
   logic [1:0] phase_r;
   logic       turboQ;
   logic       carryFuseQ;
   logic       wakeQ;
   logic       tick;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         syncA_r <= 3'h0;
         syncB_r <= 3'h0;
      end else begin
         syncA_r <= {wakePin, turboFuseBit, carryInputFuseBit};
         syncB_r <= syncA_r;
      end
   end
   assign wakeQ      = syncB_r[2];
   assign turboQ     = syncB_r[1];
   assign carryFuseQ = syncB_r[0];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) phase_r <= 2'h0;
      else       phase_r <= phase_r + 2'h1;
   end
   assign tick = turboQ | (phase_r == rex_pkg::DIV_LAST);

   // ==========================================================
   // state
   logic [PC_W-1:0] pc_r;
   logic [11:0]     ir_r;
   logic            squash_r;
   logic            chain_r;
   logic [1:0]      stall_r;
   logic            ireadPend_r;
   logic            sleeping_r;
   logic [7:0]      w_r;
   logic [7:0]      status_r;
   logic [7:0]      bank_r;
   logic [SP_W-1:0] sp_r;
   logic [7:0]      mem [256];
   logic [PC_W-1:0] stack [STACK_D];

   // ==========================================================
   // decode
   rex_alu_if aluIf ();
   rex_alu uAlu (.aif(aluIf));

   rex_pkg::rex_alu_op_e aluOp;
   logic [4:0]      fr;
   logic [7:0]      ea;
   logic [7:0]      memIdx;
   logic [7:0]      fileRd;
   logic [7:0]      bitMask;
   logic [7:0]      fileWrData;
   logic [PC_W-1:0] target;
   logic [PC_W-1:0] ireadAddr;
   logic [2:0]      page;
   logic wrW, wrF, fZ, fC, fDC, skipZ, isLit, bitOp;
   logic isJmp, isCall, isRet, isIread, isSleep, isPage, isBank;
   logic isMode, isOpt, isPort, isClrWdt, isPrefix;
   logic execEn, advance, fileWe, pcWrite, skipTaken, flow;

   assign fr   = ir_r[4:0];
   assign page = status_r[rex_pkg::ST_PAGE +: 3];
   // indirect slot uses the whole bank select value as the address
   assign ea     = (fr == rex_pkg::ADDR_IND) ? bank_r : {bank_r[7:5], fr};
   assign memIdx = ea[4] ? ea : {3'h0, ea[4:0]};

   always_comb begin
      case (ea[4:0])
         rex_pkg::ADDR_PCL:    fileRd = pc_r[7:0];
         rex_pkg::ADDR_STATUS: fileRd = status_r;
         rex_pkg::ADDR_BANK:   fileRd = bank_r;
         default:              fileRd = mem[memIdx];
      endcase
   end

   always_comb begin
      aluOp = rex_pkg::AL_PASS_A;
      wrW   = 1'b0;
      wrF   = 1'b0;
      fZ    = 1'b0;
      fC    = 1'b0;
      fDC   = 1'b0;
      skipZ = 1'b0;
      isLit = 1'b0;
      if (ir_r[11:10] == 2'b11) begin
         isLit = 1'b1;
         wrW   = 1'b1;
         fZ    = (ir_r[9:8] != 2'b00);
         case (ir_r[9:8])
            2'b00:   aluOp = rex_pkg::AL_PASS_B;
            2'b01:   aluOp = rex_pkg::AL_OR;
            2'b10:   aluOp = rex_pkg::AL_AND;
            default: aluOp = rex_pkg::AL_XOR;
         endcase
      end else if (ir_r[11:10] == 2'b00) begin
         wrF = ir_r[5];
         wrW = ~ir_r[5];
         fZ  = 1'b1;
         case (ir_r[11:6])
            6'h00: begin
               aluOp = rex_pkg::AL_PASS_B;
               wrW   = 1'b0;
               fZ    = 1'b0;
            end
            6'h01: begin
               aluOp = rex_pkg::AL_CLR;
               wrW   = ~ir_r[5] & (fr == 5'h00);
            end
            6'h02: begin
               aluOp = rex_pkg::AL_SUB;
               fC    = 1'b1;
               fDC   = 1'b1;
            end
            6'h03: aluOp = rex_pkg::AL_DEC;
            6'h04: aluOp = rex_pkg::AL_OR;
            6'h05: aluOp = rex_pkg::AL_AND;
            6'h06: aluOp = rex_pkg::AL_XOR;
            6'h07: begin
               aluOp = rex_pkg::AL_ADD;
               fC    = 1'b1;
               fDC   = 1'b1;
            end
            6'h08: aluOp = rex_pkg::AL_PASS_A;
            6'h09: aluOp = rex_pkg::AL_NOT;
            6'h0a: aluOp = rex_pkg::AL_INC;
            6'h0b: begin
               aluOp = rex_pkg::AL_DEC;
               fZ    = 1'b0;
               skipZ = 1'b1;
            end
            6'h0c: begin
               aluOp = rex_pkg::AL_RR;
               fZ    = 1'b0;
               fC    = 1'b1;
            end
            6'h0d: begin
               aluOp = rex_pkg::AL_RL;
               fZ    = 1'b0;
               fC    = 1'b1;
            end
            6'h0e: begin
               aluOp = rex_pkg::AL_SWAP;
               fZ    = 1'b0;
            end
            6'h0f: begin
               aluOp = rex_pkg::AL_INC;
               fZ    = 1'b0;
               skipZ = 1'b1;
            end
            default: aluOp = rex_pkg::AL_PASS_A;
         endcase
      end
   end

   assign aluIf.op       = aluOp;
   assign aluIf.a        = isLit ? w_r : fileRd;
   assign aluIf.b        = isLit ? ir_r[7:0] : w_r;
   assign aluIf.cIn      = status_r[rex_pkg::ST_C];
   assign aluIf.useCarry = ~carryFuseQ;

   assign bitOp    = (ir_r[11:10] == 2'b01);
   assign isJmp    = (ir_r[11:9] == rex_pkg::OP_JMP);
   assign isCall   = (ir_r[11:8] == rex_pkg::OP_CALL);
   assign isRet    = (ir_r == rex_pkg::OP_RET);
   assign isIread  = (ir_r == rex_pkg::OP_IREAD);
   assign isSleep  = (ir_r == rex_pkg::OP_SLEEP);
   assign isMode   = (ir_r == rex_pkg::OP_MODE_W);
   assign isOpt    = (ir_r == rex_pkg::OP_OPT_W);
   assign isClrWdt = (ir_r == rex_pkg::OP_CLRWDT);
   assign isPage   = (ir_r[11:3] == rex_pkg::OP_PAGE);
   assign isBank   = (ir_r[11:3] == rex_pkg::OP_BANK);
   assign isPort   = (ir_r[11:3] == rex_pkg::OP_PORT_W);
   assign isPrefix = isPage | isBank;

   assign bitMask    = 8'h01 << ir_r[7:5];
   assign fileWrData = !bitOp ? aluIf.res :
                       ir_r[8] ? (fileRd | bitMask) : (fileRd & ~bitMask);

   // ==========================================================
   // execution control
   assign advance   = tick & (stall_r == 2'h0) & ~sleeping_r;
   assign execEn    = advance & ~squash_r;
   assign fileWe    = execEn & (wrF | (bitOp & ~ir_r[9]));
   assign pcWrite   = fileWe & (ea[4:0] == rex_pkg::ADDR_PCL);
   assign skipTaken = execEn & ((skipZ & aluIf.zOut) |
                      (bitOp & ir_r[9] & (fileRd[ir_r[7:5]] == ir_r[8])));
   assign flow      = execEn & (isJmp | isCall | isRet | pcWrite);
   assign ireadAddr = PC_W'({modeReg[3:0], w_r});
   assign pmAddr    = ireadPend_r ? ireadAddr : pc_r;

   always_comb begin
      if (isRet)       target = stack[sp_r - SP_W'(1)];
      else if (isJmp)  target = PC_W'({page, ir_r[8:0]});
      else if (isCall) target = PC_W'({page, 1'b0, ir_r[7:0]});
      else             target = PC_W'({page, 1'b0, fileWrData});
   end

   // one fetched word is always in flight, so a flow change discards it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pc_r     <= PC_W'(rex_pkg::PC_RST);
         ir_r     <= rex_pkg::NOP_INSN;
         squash_r <= 1'b0;
         chain_r  <= 1'b0;
      end else if (advance) begin
         ir_r <= pmData;
         pc_r <= flow ? target : pc_r + PC_W'(1);
         if (squash_r) begin
            squash_r <= chain_r & isPrefix;
         end else begin
            squash_r <= skipTaken | flow;
            chain_r  <= skipTaken;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sp_r <= '0;
      end else if (execEn & isCall) begin
         sp_r <= sp_r + SP_W'(1);
      end else if (execEn & isRet) begin
         sp_r <= sp_r - SP_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (execEn & isCall) stack[sp_r] <= pc_r;
      if (fileWe & (ea[4:0] > rex_pkg::ADDR_BANK | ea[4] | ea[4:0] < rex_pkg::ADDR_PCL))
         mem[memIdx] <= fileWrData;
   end

   // program-memory read borrows the fetch port on the following clock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stall_r     <= 2'h0;
         ireadPend_r <= 1'b0;
      end else begin
         ireadPend_r <= execEn & isIread;
         if (execEn & isIread & turboQ) stall_r <= rex_pkg::TURBO_IREAD_STALL;
         else if (tick && stall_r != 2'h0) stall_r <= stall_r - 2'h1;
      end
   end

   // ==========================================================
   // accumulator and system registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) w_r <= rex_pkg::REG_RST;
      else if (ireadPend_r) w_r <= pmData[7:0];
      else if (execEn & wrW) w_r <= aluIf.res;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status_r <= rex_pkg::STATUS_RST;
      end else if (execEn) begin
         if (fileWe && ea[4:0] == rex_pkg::ADDR_STATUS) begin
            status_r <= fileWrData;
         end else begin
            if (fZ)  status_r[rex_pkg::ST_Z]  <= aluIf.zOut;
            if (fC)  status_r[rex_pkg::ST_C]  <= aluIf.cOut;
            if (fDC) status_r[rex_pkg::ST_DC] <= aluIf.dcOut;
            if (isPage) status_r[rex_pkg::ST_PAGE +: 3] <= ir_r[2:0];
            if (isClrWdt) begin
               status_r[rex_pkg::ST_TO] <= 1'b1;
               status_r[rex_pkg::ST_PD] <= 1'b1;
            end
            if (isSleep) status_r[rex_pkg::ST_PD] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) bank_r <= rex_pkg::REG_RST;
      else if (execEn & isBank) bank_r[7:5] <= ir_r[2:0];
      else if (fileWe && ea[4:0] == rex_pkg::ADDR_BANK) bank_r <= fileWrData;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         modeReg   <= rex_pkg::REG_RST;
         optionReg <= rex_pkg::REG_RST;
      end else begin
         if (ireadPend_r) modeReg[3:0] <= pmData[11:8];
         else if (execEn & isMode) modeReg <= w_r;
         if (execEn & isOpt) optionReg <= w_r;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         portCtrlSel  <= 3'h0;
         portCtrlData <= rex_pkg::REG_RST;
         portCtrlWr   <= 1'b0;
         wdtClear     <= 1'b0;
      end else begin
         portCtrlWr <= execEn & isPort;
         wdtClear   <= execEn & isClrWdt;
         if (execEn & isPort) begin
            portCtrlSel  <= ir_r[2:0];
            portCtrlData <= w_r;
         end
      end
   end

   // wake is level sensitive: a held wake pin ends sleep one clock after it starts
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) sleeping_r <= 1'b0;
      else if (execEn & isSleep) sleeping_r <= 1'b1;
      else if (wakeQ) sleeping_r <= 1'b0;
   end
   assign sleeping = sleeping_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence sJump;
      execEn && isJmp;
   endsequence
   sequence sTurboRead;
      execEn && isIread && turboQ;
   endsequence

   AST_LIT_W: assert property (execEn && ir_r[11:8] == 4'hc |=> w_r == $past(ir_r[7:0]))
      else $error("literal not loaded into accumulator");
   AST_ZERO_SKIP: assert property (execEn && skipZ && aluIf.zOut |=> squash_r)
      else $error("zero result did not skip");
   AST_ONE_CYCLE: assert property (turboQ && execEn && !flow && !skipTaken && !isIread
      && !isSleep |=> execEn || sleeping_r || !turboQ)
      else $error("simple instruction took extra cycles");
   AST_SKIP_TWO: assert property (turboQ && skipTaken ##1 turboQ |-> !execEn)
      else $error("skipped word was executed");
   AST_PREFIX_CHAIN: assert property (advance && squash_r && chain_r && isPrefix
      |=> squash_r)
      else $error("prefix after skip not skipped");
   AST_JUMP_FLUSH: assert property (sJump |=> squash_r && pc_r == $past(target))
      else $error("jump did not flush and redirect");
   AST_IREAD_STALL: assert property (sTurboRead ##1 turboQ[*3] |->
      !execEn && !$past(execEn, 1) && !$past(execEn, 2))
      else $error("program read did not take four clocks");
   AST_COMPAT_RATE: assert property (!turboQ && tick ##1 !turboQ |-> !tick)
      else $error("quarter rate tick too early");
   AST_ROT_CARRY: assert property (aluIf.op == rex_pkg::AL_RL |->
      aluIf.cOut == aluIf.a[7] && aluIf.res == {aluIf.a[6:0], aluIf.cIn})
      else $error("rotate left carry wrong");
   AST_NO_CARRY: assert property (aluIf.op == rex_pkg::AL_ADD && carryFuseQ |->
      aluIf.res == 8'(aluIf.a + aluIf.b))
      else $error("carry added with fuse set");
   AST_BIT_ONE: assert property (execEn && bitOp && !ir_r[9] |->
      (fileWrData & ~bitMask) == (fileRd & ~bitMask) && fileWrData[ir_r[7:5]] == ir_r[8])
      else $error("bit operation touched other bits");

endmodule

// ===== hdl/rex_pkg.sv
package rex_pkg;

   // ==========================================================
   // widths and data space
   localparam int         DATA_W      = 8;
   localparam int         INSN_W      = 12;
   localparam logic [4:0] ADDR_IND    = 5'h00;
   localparam logic [4:0] ADDR_PCL    = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_BANK   = 5'h04;

   // ==========================================================
   // flags register layout and reset values
   localparam int          ST_C       = 0;
   localparam int          ST_DC      = 1;
   localparam int          ST_Z       = 2;
   localparam int          ST_PD      = 3;
   localparam int          ST_TO      = 4;
   localparam int          ST_PAGE    = 5;
   localparam logic [7:0]  STATUS_RST = 8'h18;
   localparam logic [7:0]  REG_RST    = 8'h00;
   localparam logic [11:0] PC_RST     = 12'h000;
   localparam logic [11:0] NOP_INSN   = 12'h000;

   // ==========================================================
   // timing
   localparam logic [1:0] DIV_LAST          = 2'h3;
   localparam logic [1:0] TURBO_IREAD_STALL = 2'h3;

   // ==========================================================
   // system and flow encodings
   localparam logic [11:0] OP_CLRWDT = 12'h004;
   localparam logic [11:0] OP_RET    = 12'h800;
   localparam logic [11:0] OP_IREAD  = 12'h830;
   localparam logic [11:0] OP_SLEEP  = 12'h840;
   localparam logic [11:0] OP_MODE_W = 12'h850;
   localparam logic [11:0] OP_OPT_W  = 12'h870;
   localparam logic [8:0]  OP_PAGE   = 9'h102;
   localparam logic [8:0]  OP_BANK   = 9'h104;
   localparam logic [8:0]  OP_PORT_W = 9'h10c;
   localparam logic [3:0]  OP_CALL   = 4'h9;
   localparam logic [2:0]  OP_JMP    = 3'h5;

   typedef enum logic [3:0] {
      AL_PASS_A, AL_PASS_B, AL_CLR, AL_AND, AL_OR, AL_XOR, AL_NOT,
      AL_ADD, AL_SUB, AL_INC, AL_DEC, AL_RL, AL_RR, AL_SWAP
   } rex_alu_op_e;

endpackage

// ===== hdl/rex_alu_if.sv
`timescale 1ns/10ps
interface rex_alu_if;
   rex_pkg::rex_alu_op_e op;
   logic [7:0]           a;
   logic [7:0]           b;
   logic                 cIn;
   logic                 useCarry;
   logic [7:0]           res;
   logic                 cOut;
   logic                 dcOut;
   logic                 zOut;

   modport core (output op, a, b, cIn, useCarry, input res, cOut, dcOut, zOut);
   modport alu  (input op, a, b, cIn, useCarry, output res, cOut, dcOut, zOut);
endinterface

// ===== hdl/rex_alu.sv
`timescale 1ns/10ps
module rex_alu (
   rex_alu_if.alu aif
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic       cin;

   // ==========================================================
   // byte datapath
   always_comb begin
      cin       = 1'b0;
      sum       = 9'h000;
      nib       = 5'h00;
      aif.res   = aif.a;
      aif.cOut  = aif.cIn;
      aif.dcOut = 1'b0;
      case (aif.op)
         rex_pkg::AL_PASS_A: aif.res = aif.a;
         rex_pkg::AL_PASS_B: aif.res = aif.b;
         rex_pkg::AL_CLR:    aif.res = 8'h00;
         rex_pkg::AL_AND:    aif.res = aif.a & aif.b;
         rex_pkg::AL_OR:     aif.res = aif.a | aif.b;
         rex_pkg::AL_XOR:    aif.res = aif.a ^ aif.b;
         rex_pkg::AL_NOT:    aif.res = ~aif.a;
         rex_pkg::AL_ADD: begin
            cin       = aif.useCarry & aif.cIn;
            sum       = {1'b0, aif.a} + {1'b0, aif.b} + {8'h00, cin};
            nib       = {1'b0, aif.a[3:0]} + {1'b0, aif.b[3:0]} + {4'h0, cin};
            aif.res   = sum[7:0];
            aif.cOut  = sum[8];
            aif.dcOut = nib[4];
         end
         rex_pkg::AL_SUB: begin
            // carry set means no borrow, so a clear fuse-fed carry subtracts one more
            cin       = aif.useCarry ? aif.cIn : 1'b1;
            sum       = {1'b0, aif.a} + {1'b0, ~aif.b} + {8'h00, cin};
            nib       = {1'b0, aif.a[3:0]} + {1'b0, ~aif.b[3:0]} + {4'h0, cin};
            aif.res   = sum[7:0];
            aif.cOut  = sum[8];
            aif.dcOut = nib[4];
         end
         rex_pkg::AL_INC:    aif.res = aif.a + 8'h01;
         rex_pkg::AL_DEC:    aif.res = aif.a - 8'h01;
         rex_pkg::AL_RL: begin
            aif.res  = {aif.a[6:0], aif.cIn};
            aif.cOut = aif.a[7];
         end
         rex_pkg::AL_RR: begin
            aif.res  = {aif.cIn, aif.a[7:1]};
            aif.cOut = aif.a[0];
         end
         rex_pkg::AL_SWAP:   aif.res = {aif.a[3:0], aif.a[7:4]};
         default:            aif.res = aif.a;
      endcase
   end

   assign aif.zOut = (aif.res == 8'h00);

endmodule

// ===== verif/risc_instruction_execution_core_tb_top.sv
`timescale 1ns/10ps
module risc_instruction_execution_core_tb_top;
   logic        mclk;
   logic        rstn;
   logic        turbo;
   logic        cfBit;
   logic        wakePin;
   logic [11:0] pmAddr;
   logic [11:0] pmData;
   logic [7:0]  modeReg;
   logic [7:0]  optionReg;
   logic [2:0]  pSel;
   logic [7:0]  pDat;
   logic        pWr;
   logic        wdtClear;
   logic        sleeping;
   logic [11:0] mem [0:4095];
   logic [31:0] wq [$];
   int          cyc;
   int          wdtN;
   int          fail_count;
   int          n_compared;

   // ==========================================================
   // clock, program memory, design
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   assign pmData = mem[pmAddr];
   rex_core dut_u (.mclk(mclk), .rstn(rstn), .pmAddr(pmAddr), .pmData(pmData),
      .carryInputFuseBit(cfBit), .turboFuseBit(turbo), .wakePin(wakePin),
      .modeReg(modeReg), .optionReg(optionReg), .portCtrlSel(pSel),
      .portCtrlData(pDat), .portCtrlWr(pWr), .wdtClear(wdtClear), .sleeping(sleeping));

   // ==========================================================
   // log of port writes: cycle, index, data
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rstn !== 1'b1) begin
         wq.delete();
         wdtN <= 0;
      end
      if (pWr === 1'b1)
         wq.push_back({cyc[20:0], pSel, pDat});
      if (wdtClear === 1'b1)
         wdtN <= wdtN + 1;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input int k, input logic [2:0] s, input logic [7:0] d);
      chk("port write", {21'h0, wq[k][10:0]}, {21'h0, s, d});
   endtask

   // missing entries read as unknown, so a lost write cannot pass
   function automatic logic [31:0] gap(input int k);
      return wq[k][31:11] - wq[k-1][31:11];
   endfunction

   // leading nops cover the fuse synchronisers after reset
   task automatic runp(input logic [11:0] p[$], input logic tb, input logic cf, input int n);
      for (int i = 0; i < 4096; i++)
         mem[i] = (i < p.size()) ? p[i] : 12'h000;
      turbo = tb;
      cfBit = cf;
      wakePin = 1'b0;
      rstn = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rstn = 1'b1;
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_logic();
      runp('{12'h000, 12'h000, 12'hc5a, 12'h860, 12'he0f, 12'h861, 12'hd30, 12'h862,
             12'hfff, 12'h863}, 1'b1, 1'b1, 30);
      chk("writes", wq.size(), 4);
      wr(0, 3'h0, 8'h5a);
      wr(1, 3'h1, 8'h0a);
      wr(2, 3'h2, 8'h3a);
      wr(3, 3'h3, 8'hc5);
      chk("gap", gap(3), 2);
   endtask

   task automatic t_skip();
      runp('{12'h000, 12'h000, 12'hcff, 12'h028, 12'h860, 12'h3e8, 12'h810, 12'h820,
             12'h861, 12'h862, 12'h2e8, 12'h863}, 1'b1, 1'b1, 30);
      chk("writes", wq.size(), 3);
      wr(1, 3'h2, 8'hff);
      wr(2, 3'h3, 8'hff);
      chk("gap", gap(1), 5);
      chk("gap", gap(2), 2);
   endtask

   task automatic t_flow();
      runp('{12'h000, 12'h000, 12'hc11, 12'h860, 12'h908, 12'h861, 12'ha0a, 12'h863,
             12'h862, 12'h800, 12'h864, 12'ha0b}, 1'b1, 1'b1, 30);
      chk("writes", wq.size(), 4);
      wr(1, 3'h2, 8'h11);
      wr(2, 3'h1, 8'h11);
      wr(3, 3'h4, 8'h11);
      chk("gap", gap(1), 3);
      chk("gap", gap(3), 3);
   endtask

   task automatic t_bits();
      runp('{12'h000, 12'h000, 12'hc81, 12'h029, 12'h549, 12'h4e9, 12'h209, 12'h860,
             12'h709, 12'h861, 12'h629, 12'h862, 12'h863}, 1'b1, 1'b1, 30);
      chk("writes", wq.size(), 2);
      wr(0, 3'h0, 8'h05);
      wr(1, 3'h3, 8'h05);
   endtask

   task automatic t_carry();
      for (int cf = 0; cf < 2; cf++) begin
         runp('{12'h000, 12'h000, 12'h503, 12'hc01, 12'h02a, 12'hc01, 12'h1ca, 12'h860},
              1'b1, cf[0], 20);
         wr(0, 3'h0, (cf == 0) ? 8'h03 : 8'h02);
      end
   endtask

   task automatic t_rate();
      runp('{12'h000, 12'h000, 12'hc5a, 12'h860, 12'h861}, 1'b0, 1'b1, 40);
      wr(1, 3'h1, 8'h5a);
      chk("gap", gap(1), 4);
   endtask

   // iread of its own word, rotates through carry, indirect jump via address 02
   task automatic t_misc();
      runp('{12'h000, 12'h000, 12'hc04, 12'h865, 12'h830, 12'h860, 12'hc81, 12'h02b,
             12'h34b, 12'h861, 12'h30b, 12'h862, 12'hc10, 12'h022, 12'h863, 12'h000,
             12'h864, 12'ha11}, 1'b1, 1'b1, 40);
      chk("writes", wq.size(), 5);
      chk("iread mode", modeReg, 8'h08);
      wr(0, 3'h5, 8'h04);
      wr(1, 3'h0, 8'h30);
      wr(2, 3'h1, 8'h02);
      wr(3, 3'h2, 8'hc0);
      wr(4, 3'h4, 8'h10);
      chk("gap", gap(1), 5);
      chk("gap", gap(4), 4);
   endtask

   task automatic t_sys();
      runp('{12'h000, 12'h000, 12'h004, 12'h813, 12'h203, 12'h860, 12'hc3c, 12'h870,
             12'hc05, 12'h850, 12'h840}, 1'b1, 1'b1, 30);
      chk("wdt clears", wdtN, 1);
      chk("page bits", wq[0][7:5], 3'h3);
      chk("option", optionReg, 8'h3c);
      chk("mode", modeReg, 8'h05);
      chk("sleeping", sleeping, 1'b1);
      wakePin = 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      chk("sleeping", sleeping, 1'b0);
   endtask

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      turbo = 1'b1;
      cfBit = 1'b1;
      wakePin = 1'b0;
      t_logic();
      t_skip();
      t_flow();
      t_bits();
      t_carry();
      t_rate();
      t_misc();
      t_sys();
      test_done();
   end

   // all scenarios need about 1.5 us
   initial begin
      #20000;
      fail_count++;
      test_done();
   end
endmodule
